// File: disk_ecc_burst_corrector.sv
// Purpose: Programmable ECC shift register with burst error correction cycle
// Assumes: APB slave, single clock mclk, synchronous active-low reset
// Notes:   Syndrome byte 0 is the most significant byte of the shift register
//
// Operation
// - Corrects one contiguous burst up to fifteen bits long.
// - Drive commands written during correction are ignored.
// - Status bit 6 shows correction active, set at start, cleared at end.
// - Syndrome is transposed so the search runs as a reverse shift.
// - Each shift tests the upper width-minus-span bits for zero.
// - After eight shifts, counter decrements per byte and freezes on detect.
// - Counter exhausted before zero detect sets the correction failed flag.
// - Either ending pulses the interrupt and clears the active flag.
// - Final syndrome is bit aligned, one byte further, from byte one.
// - 32-bit syndrome sits in bytes 0, 1, 4, 5; bytes 2, 3 read zero.
// - 48-bit syndrome sits in bytes 1, 2, 3; others zero if correctable.
// - Each preset byte the format uses loads its shift register byte at preset; the other bytes clear.
// - Four-bit span 3 to 15; out of range falls back to three.
// - Encapsulation bits decide if mark and sync bits enter the code.
// - Data entering and leaving the shift register may be inverted.
// - Format selects 32-bit or 48-bit ECC, or fixed 16-bit CRC.
`timescale 1ns/1ps
`include "ecc_corr_map.svh"

module disk_ecc_burst_corrector (
	input  wire logic                mclk,
	input  wire logic                rst_n,
	input  wire logic                psel,
	input  wire logic                penable,
	input  wire logic                pwrite,
	input  wire logic [7:0]          paddr,
	input  wire logic [31:0]         pwdata,
	output logic      [31:0]         prdata,
	output logic                     pready,
	output logic                     pslverr,
	input  wire ecc_corr_pkg::ser_in_t serIn,
	input  wire logic                presetReq,
	output logic                     checkBit,
	output logic                     checkBitValid,
	output ecc_corr_pkg::drv_cmd_t   drvCmd,
	output logic                     corrIrq,
	output logic                     corrActive
);
	import ecc_corr_pkg::*;

	////////////////////////////////////////////////////////////////////////////
	logic [7:0]  tapByte [6];
	logic [7:0]  preByte [6];
	logic [7:0]  synByte [6];
	logic [47:0] tapVec;
	logic [47:0] preVec;
	logic [47:0] sr;
	ctrl_t       ctrl;
	code_t       code;
	corr_state_t state;
	logic [15:0] byteCnt;
	logic [2:0]  phase;
	logic        firstByte;
	logic        corrFail;

	logic        setupPhase;
	logic        accessDone;
	logic        wrEn;
	logic        rdHit;
	logic [31:0] rdVal;

	logic [5:0]  width;
	logic [47:0] nMask;
	logic [47:0] topMask;
	logic [47:0] poly;
	logic [47:0] recipPoly;
	logic [47:0] view;
	logic [47:0] spanMask;
	logic [3:0]  spanEff;
	logic        zeroDetect;
	logic        topBit;
	logic        serUse;
	logic        serIn0;
	logic        fb;
	logic [47:0] fwdNext;
	logic [47:0] revNext;
	logic [47:0] transposed;
	logic [47:0] finalView;
	logic        startReq;

	////////////////////////////////////////////////////////////////////////////
	function automatic logic [47:0] bitrev48(input logic [47:0] v);
		logic [47:0] r;
		r = '0;
		for (int i = 0; i < 48; i++) begin
			r[i] = v[47 - i];
		end
		return r;
	endfunction : bitrev48

	// 32-bit codes live in bytes 0, 1, 4 and 5 so bytes 2 and 3 stay idle
	function automatic logic [47:0] toView(input logic [47:0] s, input code_t c);
		logic [47:0] r;
		r = '0;
		unique case (c)
			CODE_ECC48: r = s;
			CODE_ECC32: r = {16'h0000, s[47:32], s[15:0]};
			default:    r = {32'h0000_0000, s[15:0]};
		endcase
		return r;
	endfunction : toView

	function automatic logic [47:0] fromView(input logic [47:0] v, input code_t c);
		logic [47:0] r;
		r = '0;
		unique case (c)
			CODE_ECC48: r = v;
			CODE_ECC32: r = {v[31:16], 16'h0000, v[15:0]};
			default:    r = {32'h0000_0000, v[15:0]};
		endcase
		return r;
	endfunction : fromView

	////////////////////////////////////////////////////////////////////////////
	// Byte i of each register bank maps to one byte lane of the wide vectors
	for (genvar i = 0; i < 6; i++) begin : gLane
		assign synByte[i]             = sr[47 - 8 * i -: 8];
		assign tapVec[47 - 8 * i -: 8] = tapByte[i];
		assign preVec[47 - 8 * i -: 8] = preByte[i];
	end

	////////////////////////////////////////////////////////////////////////////
	// Code geometry
	always_comb begin
		unique case (code)
			CODE_ECC48: width = `WIDTH_E48;
			CODE_ECC32: width = `WIDTH_E32;
			default:    width = `WIDTH_CRC;
		endcase
		nMask   = (48'h1 << width) - 48'h1;
		topMask = 48'h1 << (width - 6'd1);
		if (code == CODE_ECC48 || code == CODE_ECC32) begin
			poly = (toView(~tapVec, code) & nMask) | 48'h1;
		end else begin
			poly = `CRC16_POLY;
		end
		// A spare low bit lets the full-width code shift by zero instead of by minus one
		recipPoly = (48'({bitrev48(poly), 1'b0} >> (6'd48 - width)) & nMask)
			| 48'h1;
	end

	// Span below three is out of range; four bits cannot exceed fifteen
	assign spanEff  = (ctrl.span < `SPAN_MIN) ? `SPAN_MIN : ctrl.span;
	assign spanMask = (48'h1 << spanEff) - 48'h1;

	assign view       = toView(sr, code);
	assign topBit     = |(view & topMask);
	assign zeroDetect = ((view & nMask & ~spanMask) == 48'h0);

	// Forward shift for checkbit work
	assign serUse = serIn.valid && (state == ST_IDLE) &&
		!(serIn.mark && !(serIn.header ? ctrl.headerEncapsulate
			: ctrl.dataEncapsulate));
	assign serIn0  = serIn.bitVal ^ ctrl.invIn;
	assign fb      = serIn0 ^ topBit;
	assign fwdNext = ((view << 1) & nMask) ^ (fb ? poly : 48'h0);

	// Reverse shift uses the reciprocal polynomial on transposed contents
	assign transposed = bitrev48(view) >> (6'd48 - width);
	assign revNext    = ((view << 1) & nMask) ^ (topBit ? recipPoly : 48'h0);

	// Pattern returns to the top, then moves one byte plus the bit phase down
	assign finalView = ((bitrev48(view) >> (6'd48 - width)) >> 8)
		>> phase;

	////////////////////////////////////////////////////////////////////////////
	// APB handshake
	assign setupPhase = psel && !penable;
	assign accessDone = psel && penable && pready;
	assign wrEn       = accessDone && pwrite;
	assign startReq   = wrEn && (paddr == `OPCMD_OFS) && pwdata[`OPCMD_START]
		&& (state == ST_IDLE) && (code != CODE_CRC16) && (code != CODE_RSVD);

	always_comb begin
		rdHit = 1'b0;
		rdVal = 32'h0000_0000;
		for (int i = 0; i < 6; i++) begin
			if (paddr == `SYN_BASE + 8'(4 * i)) begin
				rdHit = 1'b1;
				rdVal = {24'h00_0000, synByte[i]};
			end
			if (paddr == `TAP_BASE + 8'(4 * i)) begin
				rdHit = 1'b1;
				rdVal = {24'h00_0000, tapByte[i]};
			end
			if (paddr == `PRE_BASE + 8'(4 * i)) begin
				rdHit = 1'b1;
				rdVal = {24'h00_0000, preByte[i]};
			end
		end
		unique case (paddr)
			`CTRL_OFS: begin
				rdHit = 1'b1;
				rdVal = {24'h00_0000, ctrl};
			end
			`FMT_OFS: begin
				rdHit = 1'b1;
				rdVal = {30'h0000_0000, code};
			end
			`OPCMD_OFS, `DRV_OFS: begin
				rdHit = 1'b1;
			end
			`STAT_OFS: begin
				rdHit = 1'b1;
				rdVal[`STAT_ACTIVE] = (state == ST_SEARCH);
			end
			`ERR_OFS: begin
				rdHit = 1'b1;
				rdVal[`ERR_FAIL] = corrFail;
			end
			`CNT_OFS: begin
				rdHit = 1'b1;
				rdVal = {16'h0000, byteCnt};
			end
			default: begin
			end
		endcase
	end

	// Answer is registered at the setup edge, so access always lasts one cycle
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			pready  <= 1'b0;
			prdata  <= 32'h0000_0000;
			pslverr <= 1'b0;
		end else begin
			pready  <= setupPhase;
			prdata  <= (setupPhase && !pwrite) ? rdVal : 32'h0000_0000;
			pslverr <= setupPhase && !rdHit;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Configuration registers
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			for (int i = 0; i < 6; i++) begin
				tapByte[i] <= `TAP_RST;
				preByte[i] <= `PRE_RST;
			end
			ctrl <= `CTRL_RST;
			code <= CODE_CRC16;
		end else if (wrEn) begin
			for (int i = 0; i < 6; i++) begin
				if (paddr == `TAP_BASE + 8'(4 * i)) begin
					tapByte[i] <= pwdata[7:0];
				end
				if (paddr == `PRE_BASE + 8'(4 * i)) begin
					preByte[i] <= pwdata[7:0];
				end
			end
			if (paddr == `CTRL_OFS) begin
				ctrl <= ctrl_t'(pwdata[7:0]);
			end
			if (paddr == `FMT_OFS) begin
				code <= code_t'(pwdata[1:0]);
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Drive command port; a command during a correction cycle is dropped
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			drvCmd <= '0;
		end else begin
			drvCmd.strobe <= 1'b0;
			if (wrEn && paddr == `DRV_OFS && state == ST_IDLE) begin
				drvCmd.strobe <= 1'b1;
				drvCmd.cmd    <= pwdata[7:0];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Correction engine and shift register
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			state     <= ST_IDLE;
			sr        <= 48'h0000_0000_0000;
			byteCnt   <= `CNT_RST;
			phase     <= 3'h0;
			firstByte <= 1'b1;
			corrIrq   <= 1'b0;
		end else begin
			corrIrq <= 1'b0;
			unique case (state)
				ST_IDLE: begin
					if (startReq) begin
						state     <= ST_SEARCH;
						sr        <= fromView(transposed, code);
						phase     <= 3'h0;
						firstByte <= 1'b1;
					end else if (presetReq) begin
						sr <= fromView(toView(preVec, code), code);
					end else if (serUse) begin
						sr <= fromView(fwdNext, code);
					end
					if (wrEn && paddr == `CNT_OFS) begin
						byteCnt <= pwdata[15:0];
					end
				end
				ST_SEARCH: begin
					if (zeroDetect) begin
						state   <= ST_IDLE;
						corrIrq <= 1'b1;
						sr      <= fromView(finalView, code);
					end else begin
						sr    <= fromView(revNext, code);
						phase <= phase + 3'h1;
						if (phase == `BYTE_LAST) begin
							firstByte <= 1'b0;
							if (!firstByte) begin
								if (byteCnt == 16'h0000) begin
									state   <= ST_IDLE;
									corrIrq <= 1'b1;
								end else begin
									byteCnt <= byteCnt - 16'h0001;
								end
							end
						end
					end
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Failure flag: start clears it, exhaustion sets it, write one clears it
	// Hardware set is tested first so it beats a same-cycle clear
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			corrFail <= 1'b0;
		end else if (state == ST_SEARCH && !zeroDetect && phase == `BYTE_LAST
			&& !firstByte && byteCnt == 16'h0000) begin
			corrFail <= 1'b1;
		end else if (startReq) begin
			corrFail <= 1'b0;
		end else if (wrEn && paddr == `ERR_OFS && pwdata[`ERR_FAIL]) begin
			corrFail <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Serial check output and active flag
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			checkBit      <= 1'b0;
			checkBitValid <= 1'b0;
			corrActive    <= 1'b0;
		end else begin
			checkBit      <= topBit ^ ctrl.invOut;
			checkBitValid <= serUse;
			corrActive    <= startReq || (state == ST_SEARCH && !corrIrq
				&& !(zeroDetect || (phase == `BYTE_LAST && !firstByte
				&& byteCnt == 16'h0000)));
		end
	end

endmodule : disk_ecc_burst_corrector

// File: ecc_corr_map.svh
// Purpose: Register offsets, field positions, reset values and constants
// Assumes: APB byte addresses, one 32-bit word per register
// Notes:   Included by the burst corrector
`ifndef ECC_CORR_MAP_SVH
`define ECC_CORR_MAP_SVH
`define SYN_BASE      8'h00
`define TAP_BASE      8'h18
`define PRE_BASE      8'h30
`define CTRL_OFS      8'h48
`define FMT_OFS       8'h4C
`define OPCMD_OFS     8'h50
`define STAT_OFS      8'h54
`define ERR_OFS       8'h58
`define CNT_OFS       8'h5C
`define DRV_OFS       8'h60
`define OPCMD_START   0
`define STAT_ACTIVE   6
`define ERR_FAIL      0
`define TAP_RST       8'hFF
`define PRE_RST       8'h00
`define CTRL_RST      8'h03
`define CNT_RST       16'h0000
`define SPAN_MIN      4'h3
`define BYTE_LAST     3'h7
`define CRC16_POLY    48'h0000_0000_1021
`define WIDTH_CRC     6'd16
`define WIDTH_E32     6'd32
`define WIDTH_E48     6'd48
`endif

// File: ecc_corr_pkg.sv
// Purpose: Types shared by the burst corrector and its bench
// Assumes: Nothing beyond SystemVerilog packed types
// Notes:   Control struct follows the control byte from D7 down to D0
package ecc_corr_pkg;
	typedef enum logic [1:0] {
		CODE_CRC16,
		CODE_ECC32,
		CODE_ECC48,
		CODE_RSVD
	} code_t;
	typedef enum logic {
		ST_IDLE,
		ST_SEARCH
	} corr_state_t;
	typedef struct packed {
		logic       invOut;
		logic       dataEncapsulate;
		logic       headerEncapsulate;
		logic       invIn;
		logic [3:0] span;
	} ctrl_t;
	typedef struct packed {
		logic valid;
		logic bitVal;
		logic header;
		logic mark;
	} ser_in_t;
	typedef struct packed {
		logic       strobe;
		logic [7:0] cmd;
	} drv_cmd_t;
endpackage : ecc_corr_pkg

// File: disk_ecc_burst_corrector_properties.sv
// Purpose: Port checks for the burst corrector
// Assumes: One clock mclk, synchronous active-low rst_n
// Notes:   Attached by bind at the foot of this file
`timescale 1ns/1ps
`include "ecc_corr_map.svh"
module disk_ecc_burst_corrector_properties (
	input wire logic                   mclk,
	input wire logic                   rst_n,
	input wire logic                   psel,
	input wire logic                   penable,
	input wire logic                   pwrite,
	input wire logic [7:0]             paddr,
	input wire logic [31:0]            pwdata,
	input wire logic [31:0]            prdata,
	input wire logic                   pready,
	input wire logic                   pslverr,
	input wire ecc_corr_pkg::ser_in_t  serIn,
	input wire logic                   presetReq,
	input wire logic                   checkBit,
	input wire logic                   checkBitValid,
	input wire ecc_corr_pkg::drv_cmd_t drvCmd,
	input wire logic                   corrIrq,
	input wire logic                   corrActive
);
	import ecc_corr_pkg::*;
	logic wrStart;
	// Start may be refused, so this only bounds where a rise may come from
	assign wrStart = psel && penable && pwrite && paddr == `OPCMD_OFS && pwdata[`OPCMD_START];
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_n);
	////////////////////////////////
	ready_after_setup_a: assert property (psel && !penable |=> pready) else $error("No ready after setup");
	ready_in_access_a: assert property (pready |-> psel && penable) else $error("Ready outside access");
	error_reads_zero_a: assert property (pslverr |-> pready && prdata == 32'h0) else $error("Bad error reply");
	irq_one_cycle_a: assert property (corrIrq |=> !corrIrq) else $error("Interrupt too long");
	irq_ends_active_a: assert property (corrIrq |-> ##[0:2] !corrActive) else $error("Active stays");
	irq_needs_active_a: assert property (corrIrq |-> corrActive || $past(corrActive)) else $error("Stray irq");
	active_from_start_a: assert property ($rose(corrActive) |-> $past(wrStart) || $past(wrStart, 2)
		|| $past(wrStart, 3)) else $error("Active without start");
	no_cmd_active_a: assert property (drvCmd.strobe |-> !corrActive && !$past(corrActive))
		else $error("Command while active");
	strobe_from_write_a: assert property (drvCmd.strobe |-> $past(psel && penable && pwrite
		&& paddr == `DRV_OFS)) else $error("Strobe without write");
endmodule : disk_ecc_burst_corrector_properties
bind disk_ecc_burst_corrector disk_ecc_burst_corrector_properties disk_ecc_burst_corrector_properties_inst (
	.mclk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .serIn,
	.presetReq, .checkBit, .checkBitValid, .drvCmd, .corrIrq, .corrActive);

// File: apb_host_model.sv
// Purpose: Host side of the register bus
// Assumes: Answer comes whenever pready is seen at a rising edge
// Notes:   One idle cycle after each transfer keeps every signal to one change per step
`timescale 1ns/1ps
`include "ecc_corr_map.svh"
module apb_host_model (
	input  wire logic        mclk,
	input  wire logic [31:0] prdata,
	input  wire logic        pready,
	input  wire logic        pslverr,
	output logic             psel,
	output logic             penable,
	output logic             pwrite,
	output logic [7:0]       paddr,
	output logic [31:0]      pwdata
);
	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h0;
		pwdata = 32'h0;
	end
	////////////////////////////////
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q,
		output logic e);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk);
		penable <= 1'b1;
		do @(posedge mclk);
		while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge mclk);
	endtask : xfer
	task automatic run_correction(input logic [1:0] fmt, input logic [15:0] sectorLen);
		logic [31:0] q;
		logic        e;
		xfer(1'b1, `FMT_OFS, {30'h0, fmt}, q, e);
		xfer(1'b1, `CNT_OFS, {16'h0, sectorLen + (fmt == 2'h2 ? 16'h6 : 16'h4)}, q, e);
		xfer(1'b1, `OPCMD_OFS, 32'h1, q, e);
	endtask : run_correction
endmodule : apb_host_model

// File: disk_ecc_burst_corrector_tb.sv
// Purpose: Self-checking bench for the burst corrector
// Assumes: Host model drives the bus, bench drives serial and preset inputs
// Notes:   Taps stay all unused, so an all-ones syndrome only rotates and never clears
`timescale 1ns/1ps
`include "ecc_corr_map.svh"
module disk_ecc_burst_corrector_tb;
	import ecc_corr_pkg::*;
	logic        mclk = 1'b0;
	logic        rst_n, psel, penable, pwrite, presetReq, pready, pslverr, checkBit, checkBitValid, corrIrq, corrActive;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, q;
	logic        e;
	ser_in_t     serIn;
	drv_cmd_t    drvCmd;
	int          num_errors = 0, samples_checked = 0, irqs = 0, strobes = 0, bits = 0;
	disk_ecc_burst_corrector disk_ecc_burst_corrector_inst (.mclk, .rst_n, .psel, .penable, .pwrite, .paddr,
		.pwdata, .prdata, .pready, .pslverr, .serIn, .presetReq, .checkBit, .checkBitValid, .drvCmd, .corrIrq,
		.corrActive);
	apb_host_model apb_host_model_inst (.mclk, .prdata, .pready, .pslverr, .psel, .penable, .pwrite, .paddr, .pwdata);
	always #4 mclk = ~mclk;
	always @(posedge mclk) begin
		if (corrIrq === 1'b1) irqs++;
		if (drvCmd.strobe === 1'b1) strobes++;
		if (checkBitValid === 1'b1) bits++;
	end
	////////////////////////////////
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			num_errors++;
			$display("BAD time=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb_host_model_inst.xfer(1'b1, a, d, q, e);
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] x);
		apb_host_model_inst.xfer(1'b0, a, 32'h0, q, e);
		chk(q & m, x);
	endtask : rd
	task automatic wait_idle;
		do apb_host_model_inst.xfer(1'b0, `STAT_OFS, 32'h0, q, e);
		while (q[`STAT_ACTIVE] !== 1'b0);
	endtask : wait_idle
	task automatic conclude;
		$display("errors %0d, checks %0d", num_errors, samples_checked);
		if (num_errors == 0 && samples_checked > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask : conclude
	initial begin
		#100000;
		num_errors++;
		conclude();
	end
	initial begin
		rst_n = 1'b0;
		presetReq = 1'b0;
		serIn = '0;
		repeat (10) @(posedge mclk);
		rst_n <= 1'b1;
		@(posedge mclk);
		for (int i = 0; i < 6; i++) begin
			rd(`TAP_BASE + 8'(4 * i), 32'hFFFF_FFFF, {24'h0, `TAP_RST});
			rd(`PRE_BASE + 8'(4 * i), 32'hFFFF_FFFF, {24'h0, `PRE_RST});
		end
		rd(`CTRL_OFS, 32'hFFFF_FFFF, {24'h0, `CTRL_RST});
		rd(8'h64, 32'hFFFF_FFFF, 32'h0);
		chk({31'h0, e}, 32'h1);
		wr(`OPCMD_OFS, 32'h1);
		rd(`STAT_OFS, 32'h40, 32'h0);
		chk(irqs, 32'h0);
		// Zero syndrome: search ends at once and the count stays put
		apb_host_model_inst.run_correction(2'h1, 16'h0200);
		wait_idle();
		chk(irqs, 32'h1);
		rd(`CNT_OFS, 32'hFFFF, 32'h0204);
		rd(`ERR_OFS, 32'h1, 32'h0);
		for (int i = 0; i < 6; i++) rd(`SYN_BASE + 8'(4 * i), 32'hFF, 32'h0);
		wr(`FMT_OFS, 32'h2);
		for (int i = 0; i < 6; i++) wr(`PRE_BASE + 8'(4 * i), 32'hFF);
		presetReq <= 1'b1;
		@(posedge mclk);
		presetReq <= 1'b0;
		@(posedge mclk);
		for (int i = 0; i < 6; i++) rd(`SYN_BASE + 8'(4 * i), 32'hFF, 32'hFF);
		apb_host_model_inst.run_correction(2'h2, 16'h0002);
		rd(`STAT_OFS, 32'h40, 32'h40);
		chk({31'h0, corrActive}, 32'h1);
		wr(`DRV_OFS, 32'h5);
		wait_idle();
		chk(strobes, 32'h0);
		chk(irqs, 32'h2);
		rd(`CNT_OFS, 32'hFFFF, 32'h0);
		rd(`ERR_OFS, 32'h1, 32'h1);
		wr(`DRV_OFS, 32'h5);
		// One more edge so the strobe counter has surely run
		@(posedge mclk);
		chk(strobes, 32'h1);
		chk({24'h0, drvCmd.cmd}, 32'h5);
		for (int i = 0; i < 8; i++) begin
			serIn <= '{1'b1, i[0], 1'b0, 1'b0};
			@(posedge mclk);
		end
		serIn <= '0;
		repeat (2) @(posedge mclk);
		chk(bits, 32'h8);
		rd(`SYN_BASE + 8'h14, 32'hFF, 32'hAA);
		chk({31'h0, checkBit}, 32'h1);
		wr(`CTRL_OFS, 32'h83);
		@(posedge mclk);
		chk({31'h0, checkBit}, 32'h0);
		conclude();
	end
endmodule : disk_ecc_burst_corrector_tb
